/* logic/strc_scan_restart_ctrl.v */
`timescale 1ns/1ps
`include "strc_defs.vh"

// Summary of operation
// R1: Delay code picks 0 or 8..512 periods
// R2: Delay only between conversions of one cycle
// R3: Standby while inter-conversion delay runs
// R4: Selector advances when each conversion ends
// R5: Scan cycles separated by 24-bit interval
// R6: Counter loads interval, counts down, launches
// R7: Long interval: shutdown, power up at 256
// R8: Short interval: standby between cycles
// R9: Mode reads as 11 throughout scanning
// R10: Digital-only settings never restart
// R11: Immediate group resets, restarts after two
// R12: Trim enables restart only when changed
// R13: Scan restarts keep cycle position, except mode 11, list and interval writes, which rewind
// R14: Unused selector or delay writes ignored
// R15: Trim values restart only when enabled
// R16: Mode 11 restarts, other values stop
// R17: First_configuration_register and reserved add setup time
// R18: Unchanged first_configuration_register write restarts without setup
// R19: Setup delay applies even in standby
// R20: Restart aligns to analog master clock
// R21: Single mode ignores list, timer writes
// R22: In cycle: list write restarts scan
// R23: Between cycles: interval write restarts scan
// R24: Any list bit set selects scan mode
// R25: Channels converted from high bit down
// R26: Delay field sits in list register top
// R27: Zero interval starts next cycle at once
module strc_scan_restart_ctrl #(
  parameter [23:0] SETUP_CYC = `STRC_SETUP_MODULATOR_CLOCK
) (
  input wire clk_sys_i,
  input wire arst_n_i,
  input wire ce_i,
  input wire wr_en_i,
  input wire [3:0] wr_addr_i,
  input wire [23:0] wr_data_i,
  input wire [3:0] rd_addr_i,
  input wire modulator_clock_tick_i,
  input wire mclk_tick_i,
  input wire analog_master_clock_tick_i,
  input wire conv_done_i,
  output reg [23:0] rd_data_o,
  output reg conv_start_o,
  output reg conv_abort_o,
  output reg [1:0] adc_mode_o,
  output reg [3:0] chan_o,
  output reg scan_active_o,
  output reg restart_busy_o
);

  // ----------------------------------------------------------------
  // Sequencer states
  // ----------------------------------------------------------------
  localparam [2:0] S_IDLE = 3'h0;
  localparam [2:0] S_RSTW = 3'h1;
  localparam [2:0] S_SETUP = 3'h2;
  localparam [2:0] S_CONV = 3'h3;
  localparam [2:0] S_DLY = 3'h4;
  localparam [2:0] S_TIMER = 3'h5;
  localparam [23:0] SETUP_P1 = SETUP_CYC + 24'h000001;

  // ----------------------------------------------------------------
  // Helper functions
  // ----------------------------------------------------------------
  // Highest enabled channel at or below top; bit 4 set when none
  function [4:0] pick;
    input [15:0] lst;
    input [3:0] top;
    integer k;
    begin
      pick = 5'h10;
      for (k = 0; k < 16; k = k + 1) begin
        if (lst[k] && (k <= top)) begin
          pick = {1'b0, k[3:0]}; // R25
        end
      end
    end
  endfunction

  // Delay length in modulator periods for a 3-bit code
  function [23:0] dly_len;
    input [2:0] code;
    begin
      if (code == 3'h0) begin
        dly_len = 24'h000000;
      end else begin
        dly_len = `STRC_DLY_BASE << code; // R1
      end
    end
  endfunction

  // ----------------------------------------------------------------
  // Reset synchroniser
  // ----------------------------------------------------------------
  reg rst_meta_reg; // First stage, read only by second
  reg rst_n_reg; // Released reset for the design

  // Release through two flops; assertion stays asynchronous
  always @(posedge clk_sys_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      rst_meta_reg <= 1'b0;
      rst_n_reg <= 1'b0;
    end else begin
      rst_meta_reg <= 1'b1;
      rst_n_reg <= rst_meta_reg;
    end
  end

  // ----------------------------------------------------------------
  // Storage and state
  // ----------------------------------------------------------------
  reg [23:0] regs [0:15]; // Register image
  reg [2:0] state_reg; // Sequencer state
  reg [23:0] cnt_reg; // Setup, delay and interval counter
  reg [1:0] mcnt_reg; // Master clock periods after a reset
  reg setup_f_reg; // Current restart needs setup time
  reg whole_f_reg; // Current restart rewinds the scan
  reg setup_pend_reg; // Setup owed from a write while idle
  reg shdn_reg; // Converter shut down during interval

  wire [1:0] mode_w = regs[`STRC_ADDR_CFG0][`STRC_MODE_MSB:`STRC_MODE_LSB];
  wire [15:0] list_w = regs[`STRC_ADDR_SCAN][`STRC_LIST_MSB:0];
  wire [2:0] dly_w = regs[`STRC_ADDR_SCAN][`STRC_DLY_MSB:`STRC_DLY_LSB]; // R26
  wire [23:0] timer_w = regs[`STRC_ADDR_TIMER];
  wire [7:0] cfg3_w = regs[`STRC_ADDR_CFG3][7:0];
  wire scan_w = |list_w; // R24
  wire running_w = (mode_w == `STRC_MODE_CONV);
  wire [23:0] old_w = regs[wr_addr_i];
  wire [4:0] first_w = pick(list_w, 4'hf);
  wire [4:0] next_w = pick(list_w, chan_o - 4'h1);
  wire has_next_w = (chan_o != 4'h0) && !next_w[4]; // R2

  // ----------------------------------------------------------------
  // Write classification
  // ----------------------------------------------------------------
  reg rq_rst; // Write asks for reset and restart
  reg rq_setup; // Restart must add setup time
  reg rq_whole; // Restart rewinds the whole scan
  reg rq_stop; // Write stops conversions

  // Sort each write into its restart group
  always @* begin
    rq_rst = 1'b0;
    rq_setup = 1'b0;
    rq_whole = 1'b0;
    rq_stop = 1'b0;
    if (wr_en_i) begin
      case (wr_addr_i)
        `STRC_ADDR_CFG0: begin
          if (wr_data_i[1:0] != `STRC_MODE_CONV) begin
            rq_stop = 1'b1; // R16
          end else begin
            rq_rst = 1'b1; // R16
            rq_whole = scan_w; // R16
            rq_setup = (wr_data_i[`STRC_CFG0_MSB:2] != old_w[`STRC_CFG0_MSB:2]); // R17 R18
          end
        end
        `STRC_ADDR_CFG1, `STRC_ADDR_CFG2: begin
          rq_rst = 1'b1; // R11 R13
        end
        `STRC_ADDR_CFG3: begin
          // Sequence, format and link bits alone never restart
          rq_rst = (wr_data_i[1:0] != old_w[1:0]); // R10 R12
        end
        `STRC_ADDR_MUX: begin
          rq_rst = !scan_w; // R14
        end
        `STRC_ADDR_SCAN: begin
          if (!scan_w) begin
            // Single mode: only entering scan counts
            rq_rst = |wr_data_i[`STRC_LIST_MSB:0]; // R21 R14
            rq_whole = 1'b1;
          end else begin
            rq_rst = (state_reg != S_TIMER); // R22 R23
            rq_whole = 1'b1; // R22
          end
        end
        `STRC_ADDR_TIMER: begin
          rq_rst = scan_w && (state_reg == S_TIMER); // R21 R22 R23
          rq_whole = 1'b1; // R23
        end
        `STRC_ADDR_OFFCAL: begin
          rq_rst = cfg3_w[`STRC_OFFEN_BIT]; // R15
        end
        `STRC_ADDR_GAINCAL: begin
          rq_rst = cfg3_w[`STRC_GAINEN_BIT]; // R15
        end
        `STRC_ADDR_RSVB, `STRC_ADDR_RSVC: begin
          rq_rst = 1'b1; // R17
          rq_setup = 1'b1; // R17
        end
        default: begin
          rq_rst = 1'b0; // R10
        end
      endcase
    end
  end

  // Mode 11 write starts even from idle; others need a running block
  wire go_w = rq_rst && (running_w || (wr_addr_i == `STRC_ADDR_CFG0));

  // ----------------------------------------------------------------
  // Sequencer
  // ----------------------------------------------------------------
  integer i;

  // Register file, restart handling and scan timing in one process
  always @(posedge clk_sys_i or negedge rst_n_reg) begin
    if (!rst_n_reg) begin
      for (i = 0; i < 16; i = i + 1) begin
        regs[i] <= `STRC_REG_RESET;
      end
      state_reg <= S_IDLE;
      cnt_reg <= 24'h000000;
      mcnt_reg <= 2'h0;
      setup_f_reg <= 1'b0;
      whole_f_reg <= 1'b0;
      setup_pend_reg <= 1'b0;
      shdn_reg <= 1'b0;
      rd_data_o <= 24'h000000;
      conv_start_o <= 1'b0;
      conv_abort_o <= 1'b0;
      adc_mode_o <= `STRC_MODE_SHDN;
      chan_o <= 4'h0;
      scan_active_o <= 1'b0;
      restart_busy_o <= 1'b0;
    end else if (ce_i) begin
      conv_start_o <= 1'b0;
      conv_abort_o <= 1'b0;
      if (wr_en_i) begin
        regs[wr_addr_i] <= wr_data_i;
      end
      // Readback hides the internal power state while scanning
      if ((rd_addr_i == `STRC_ADDR_CFG0) && scan_active_o) begin
        rd_data_o <= {regs[rd_addr_i][23:2], `STRC_MODE_CONV}; // R9
      end else begin
        rd_data_o <= regs[rd_addr_i];
      end
      scan_active_o <= scan_w && (state_reg != S_IDLE);
      restart_busy_o <= (state_reg == S_RSTW) || (state_reg == S_SETUP);
      if (rq_stop) begin
        // Any mode other than 11 halts the sequencer
        conv_abort_o <= (state_reg != S_IDLE); // R16
        state_reg <= S_IDLE;
        adc_mode_o <= wr_data_i[1:0];
      end else if (go_w) begin
        // Reset is immediate; restart waits for the master clock
        conv_abort_o <= (state_reg != S_IDLE); // R11
        state_reg <= S_RSTW;
        mcnt_reg <= 2'h0;
        setup_f_reg <= rq_setup || setup_pend_reg; // R17 R19
        setup_pend_reg <= 1'b0;
        whole_f_reg <= rq_whole; // R13
      end else begin
        if (rq_rst) begin
          // Idle standby still owes the setup time later
          setup_pend_reg <= setup_pend_reg || rq_setup; // R19
        end
        case (state_reg)
          S_RSTW: begin
            if (mcnt_reg != `STRC_RESTART_MCLK) begin
              if (mclk_tick_i) begin
                mcnt_reg <= mcnt_reg + 2'h1; // R11
              end
            end else if (analog_master_clock_tick_i) begin
              // Waiting for the clock phase may stretch two periods to four
              if (whole_f_reg && scan_w) begin
                chan_o <= first_w[3:0]; // R16 R22 R23
              end
              if (setup_f_reg) begin
                state_reg <= S_SETUP; // R17
                cnt_reg <= SETUP_CYC;
                adc_mode_o <= `STRC_MODE_CONV;
              end else begin
                state_reg <= S_CONV; // R18
                conv_start_o <= 1'b1;
                adc_mode_o <= `STRC_MODE_CONV;
              end
            end // R20
          end
          S_SETUP: begin
            if (modulator_clock_tick_i) begin
              cnt_reg <= cnt_reg - 24'h000001;
              if (cnt_reg <= 24'h000001) begin
                state_reg <= S_CONV; // R17
                conv_start_o <= 1'b1;
              end
            end
          end
          S_CONV: begin
            if (conv_done_i) begin
              if (scan_w && has_next_w) begin
                chan_o <= next_w[3:0]; // R4
                if (dly_w != 3'h0) begin
                  state_reg <= S_DLY;
                  cnt_reg <= dly_len(dly_w); // R1
                  adc_mode_o <= `STRC_MODE_STBY; // R3
                end else begin
                  conv_start_o <= 1'b1; // R1
                end
              end else if (cfg3_w[`STRC_SEQ_MSB:`STRC_SEQ_LSB] == `STRC_SEQ_CONT) begin
                if (scan_w) begin
                  chan_o <= first_w[3:0]; // R25
                end
                if (!scan_w || (timer_w == 24'h000000)) begin
                  conv_start_o <= 1'b1; // R27
                end else begin
                  state_reg <= S_TIMER;
                  cnt_reg <= timer_w; // R5 R6
                  shdn_reg <= (timer_w > SETUP_CYC);
                  // Long waits shut down, short ones only idle
                  adc_mode_o <= (timer_w > SETUP_CYC) ? `STRC_MODE_SHDN
                                                      : `STRC_MODE_STBY; // R7 R8
                end
              end else begin
                // One-shot finished: mode field falls back to standby
                state_reg <= S_IDLE;
                adc_mode_o <= `STRC_MODE_STBY;
                regs[`STRC_ADDR_CFG0][1:0] <= `STRC_MODE_STBY;
              end
            end
          end
          S_DLY: begin
            if (modulator_clock_tick_i) begin
              cnt_reg <= cnt_reg - 24'h000001;
              if (cnt_reg <= 24'h000001) begin
                state_reg <= S_CONV; // R1
                conv_start_o <= 1'b1;
                adc_mode_o <= `STRC_MODE_CONV;
              end
            end
          end
          S_TIMER: begin
            if (modulator_clock_tick_i) begin
              cnt_reg <= cnt_reg - 24'h000001; // R6
              if (shdn_reg && (cnt_reg == SETUP_P1)) begin
                adc_mode_o <= `STRC_MODE_CONV; // R7
              end
              if (cnt_reg <= 24'h000001) begin
                state_reg <= S_CONV; // R6
                conv_start_o <= 1'b1;
                adc_mode_o <= `STRC_MODE_CONV;
              end
            end
          end
          default: begin
            state_reg <= S_IDLE;
          end
        endcase
      end
    end
  end

endmodule

/* logic/strc_defs.vh */
`ifndef STRC_DEFS_VH
`define STRC_DEFS_VH
// ----------------------------------------------------------------
// Register addresses
// ----------------------------------------------------------------
`define STRC_ADDR_CFG0 4'h1
`define STRC_ADDR_CFG1 4'h2
`define STRC_ADDR_CFG2 4'h3
`define STRC_ADDR_CFG3 4'h4
`define STRC_ADDR_MUX 4'h6
`define STRC_ADDR_SCAN 4'h7
`define STRC_ADDR_TIMER 4'h8
`define STRC_ADDR_OFFCAL 4'h9
`define STRC_ADDR_GAINCAL 4'ha
`define STRC_ADDR_RSVB 4'hb
`define STRC_ADDR_RSVC 4'hc
// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define STRC_MODE_MSB 1
`define STRC_MODE_LSB 0
`define STRC_CFG0_MSB 7
`define STRC_SEQ_MSB 7
`define STRC_SEQ_LSB 6
`define STRC_OFFEN_BIT 1
`define STRC_GAINEN_BIT 0
`define STRC_DLY_MSB 23
`define STRC_DLY_LSB 21
`define STRC_LIST_MSB 15
// ----------------------------------------------------------------
// Codes, reset values and timing
// ----------------------------------------------------------------
`define STRC_MODE_SHDN 2'h0
`define STRC_MODE_STBY 2'h2
`define STRC_MODE_CONV 2'h3
`define STRC_SEQ_CONT 2'h3
`define STRC_REG_RESET 24'h000000
`define STRC_SETUP_MODULATOR_CLOCK 24'h000100
`define STRC_DLY_BASE 24'h000004
`define STRC_RESTART_MCLK 2'h2
`endif

/* tb/strc_properties.sv */
`timescale 1ns/1ps
`include "strc_defs.vh"
// ----------------------------------------
// Port checks of scan timing and restarts
// ----------------------------------------
module strc_checker (
  input wire clk_sys_i,
  input wire arst_n_i,
  input wire ce_i,
  input wire wr_en_i,
  input wire [3:0] wr_addr_i,
  input wire [23:0] wr_data_i,
  input wire [3:0] rd_addr_i,
  input wire [23:0] rd_data_o,
  input wire conv_start_o,
  input wire conv_abort_o,
  input wire [1:0] adc_mode_o,
  input wire scan_active_o,
  input wire restart_busy_o
);
  wire wr = ce_i && wr_en_i; // Write taken this edge
  wire w_mux = wr && wr_addr_i == `STRC_ADDR_MUX;
  wire w_tmr = wr && wr_addr_i == `STRC_ADDR_TIMER;
  wire w_scn = wr && wr_addr_i == `STRC_ADDR_SCAN;
  wire w_cfg = wr && wr_addr_i == `STRC_ADDR_CFG0;
  reg [23:0] tmr_reg; // Zero interval means no gap between cycles
  // Shadow of the interval, so in-cycle moments are known
  always @(posedge clk_sys_i or negedge arst_n_i) begin
    if (!arst_n_i)
      tmr_reg <= 24'h000000;
    else if (w_tmr)
      tmr_reg <= wr_data_i;
  end
  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (!arst_n_i);
  a_mux_scan_quiet: assert property (
    w_mux && scan_active_o |=> !conv_abort_o [*2]) else $error("selector restart");
  a_timer_single_quiet: assert property (
    w_tmr && !scan_active_o |=> !conv_abort_o [*2]) else $error("interval restart");
  a_list_cycle_restart: assert property (
    w_scn && tmr_reg == 24'h000000 && scan_active_o && adc_mode_o == 2'h3 &&
    !restart_busy_o |-> ##[1:2] conv_abort_o) else $error("list write ignored");
  a_timer_gap_restart: assert property (
    w_tmr && scan_active_o && adc_mode_o == 2'h0 |-> ##[1:2] conv_abort_o)
    else $error("gap interval write ignored");
  a_stop_no_start: assert property (
    w_cfg && wr_data_i[1:0] != 2'h3 |=> !conv_start_o [*8]) else $error("no stop");
  a_abort_no_start: assert property (
    conv_abort_o |-> !conv_start_o [*2]) else $error("restart too early");
  a_busy_bounded: assert property (
    $rose(restart_busy_o) |-> ##[1:1000] !restart_busy_o) else $error("restart hung");
  a_start_mode_on: assert property (
    conv_start_o |-> adc_mode_o == 2'h3) else $error("start while powered down");
  a_mode_read_11: assert property (
    rd_addr_i == `STRC_ADDR_CFG0 && scan_active_o && $past(scan_active_o)
    |=> rd_data_o[1:0] == 2'h3) else $error("mode field not 11");
  cover property (w_tmr && adc_mode_o == 2'h0 && scan_active_o);
  cover property ($rose(restart_busy_o));
  cover property (conv_start_o && scan_active_o);
endmodule
bind strc_scan_restart_ctrl strc_checker u_chk (.clk_sys_i(clk_sys_i),
  .arst_n_i(arst_n_i), .ce_i(ce_i), .wr_en_i(wr_en_i), .wr_addr_i(wr_addr_i),
  .wr_data_i(wr_data_i), .rd_addr_i(rd_addr_i), .rd_data_o(rd_data_o),
  .conv_start_o(conv_start_o), .conv_abort_o(conv_abort_o), .adc_mode_o(adc_mode_o),
  .scan_active_o(scan_active_o), .restart_busy_o(restart_busy_o));

/* tb/strc_conv_model.sv */
`timescale 1ns/1ps
// ----------------------------------------
// Converter and clock divider model
// ----------------------------------------
module strc_conv_model (
  input wire clk_sys_i,
  input wire start_i,
  input wire abort_i,
  output reg dm_tick_o = 1'b0,
  output reg mc_tick_o = 1'b0,
  output reg am_tick_o = 1'b0,
  output reg done_o = 1'b0
);
  reg [2:0] ph_reg = 3'h0; // Divider phase
  int left = 0; // Cycles left in the conversion
  // Launched off the falling edge; alignment ticks are
  // rarer than master ticks, so restarts stretch as they may
  always @(negedge clk_sys_i) begin
    ph_reg <= ph_reg + 3'h1;
    dm_tick_o <= ph_reg[0];
    mc_tick_o <= ph_reg[1:0] == 2'h3;
    am_tick_o <= ph_reg == 3'h7;
    done_o <= left == 1;
    if (abort_i)
      left <= 0; // Discarded conversion never reports
    else if (start_i)
      left <= 20;
    else if (left > 0)
      left <= left - 1;
  end
endmodule

/* tb/scan_timing_and_restart_ctrl_test.sv */
`timescale 1ns/1ps
`include "strc_defs.vh"
module scan_timing_and_restart_ctrl_test;
  // ----------------------------------------
  // Stimulus, outputs and counters
  // ----------------------------------------
  reg clk_sys_i = 1'b0;
  reg arst_n_i = 1'b0;
  reg wr_en_i = 1'b0;
  reg [3:0] wr_addr_i = 4'h0;
  reg [23:0] wr_data_i = 24'h000000;
  reg [3:0] rd_addr_i = 4'h0;
  wire dm, mc, am, done, start, abort, busy, sact;
  wire [23:0] rdata;
  wire [1:0] mode;
  wire [3:0] chan;
  int n_errors = 0;
  int compares = 0;
  int cyc = 0;
  int k;
  always #5 clk_sys_i = ~clk_sys_i;
  strc_scan_restart_ctrl dut (.clk_sys_i(clk_sys_i), .arst_n_i(arst_n_i),
    .ce_i(1'b1), .wr_en_i(wr_en_i), .wr_addr_i(wr_addr_i), .wr_data_i(wr_data_i),
    .rd_addr_i(rd_addr_i), .modulator_clock_tick_i(dm), .mclk_tick_i(mc), .analog_master_clock_tick_i(am),
    .conv_done_i(done), .rd_data_o(rdata), .conv_start_o(start), .conv_abort_o(abort),
    .adc_mode_o(mode), .chan_o(chan), .scan_active_o(sact), .restart_busy_o(busy));
  strc_conv_model far (.clk_sys_i(clk_sys_i), .start_i(start), .abort_i(abort),
    .dm_tick_o(dm), .mc_tick_o(mc), .am_tick_o(am), .done_o(done));
  // Hang guard
  always @(posedge clk_sys_i) begin
    cyc++;
    if (cyc == 40000) begin
      n_errors++;
      report_and_stop;
    end
  end
  // ----------------------------------------
  // Tasks
  // ----------------------------------------
  task chk(input [23:0] seen, input [23:0] exp);
    compares++;
    if (seen !== exp) begin
      n_errors++;
      $display("ERROR %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task wr(input [3:0] a, input [23:0] d);
    @(negedge clk_sys_i);
    wr_en_i = 1'b1;
    wr_addr_i = a;
    wr_data_i = d;
    @(negedge clk_sys_i);
    wr_en_i = 1'b0;
  endtask
  task rd(input [3:0] a, input [23:0] e);
    @(negedge clk_sys_i);
    rd_addr_i = a;
    @(negedge clk_sys_i);
    chk(rdata, e);
  endtask
  // Write, then look for a discard over the next two cycles
  task wx(input [3:0] a, input [23:0] d, input ab);
    reg seen;
    wr(a, d);
    seen = abort;
    @(negedge clk_sys_i);
    chk(seen | abort, ab);
  endtask
  task wstart;
    int i;
    @(negedge clk_sys_i);
    for (i = 0; i < 3000 && start !== 1'b1; i++) @(negedge clk_sys_i);
  endtask
  // Sampled on the rising edge, before that edge's updates land
  task wdone(input [3:0] c);
    int i;
    @(posedge clk_sys_i);
    for (i = 0; i < 3000 && !(done === 1'b1 && chan === c); i++) @(posedge clk_sys_i);
  endtask
  // Modulator ticks from a conversion end until power-up and next start
  task gap(input [3:0] c, input [3:0] nxt, input [1:0] m0, input int won, input int wst);
    int n;
    int on;
    n = 0;
    on = -1;
    wdone(c);
    @(posedge clk_sys_i);
    chk(mode, m0);
    chk(chan, nxt);
    repeat (3000) begin
      if (mode === 2'h3 && on < 0) on = n;
      if (start === 1'b1) break;
      if (dm === 1'b1) n++;
      @(posedge clk_sys_i);
    end
    chk(rdata[1:0], 2'h3);
    chk(on, won);
    chk(n, wst);
  endtask
  // Restart write; long means the setup time was added
  task rlen(input [3:0] a, input [23:0] d, input lg);
    int n;
    n = 0;
    wr(a, d);
    repeat (3000) begin
      @(posedge clk_sys_i);
      if (start === 1'b1) break;
      if (dm === 1'b1) n++;
    end
    chk(n >= 256, lg);
  endtask
  task report_and_stop;
    $display("compares %0d n_errors %0d", compares, n_errors);
    if (n_errors == 0 && compares > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    repeat (10) @(negedge clk_sys_i);
    arst_n_i = 1'b1;
    repeat (3) @(negedge clk_sys_i);
    rd(`STRC_ADDR_TIMER, 24'h000000);
    wr(`STRC_ADDR_TIMER, 24'hffffff);
    rd(`STRC_ADDR_TIMER, 24'hffffff);
    rd_addr_i = `STRC_ADDR_CFG0;
    wr(`STRC_ADDR_CFG3, 24'h0000c0);
    wr(`STRC_ADDR_TIMER, 24'h000000);
    wr(`STRC_ADDR_SCAN, 24'h000003);
    wr(`STRC_ADDR_CFG0, 24'h000003);
    // Every delay code on a two-channel list
    for (k = 0; k < 8; k++) begin
      wstart;
      wx(`STRC_ADDR_SCAN, {k[2:0], 21'h000003}, 1'b1);
      gap(4'h1, 4'h0, k ? 2'h2 : 2'h3, k ? 8 << (k - 1) : 0, k ? 8 << (k - 1) : 0);
      gap(4'h0, 4'h1, 2'h3, 0, 0);
    end
    wx(`STRC_ADDR_MUX, 24'h000001, 1'b0);
    wdone(4'h1);
    wstart;
    wx(`STRC_ADDR_CFG1, 24'h000001, 1'b1);
    wstart;
    chk(chan, 4'h0);
    // Long and short waits between cycles
    wr(`STRC_ADDR_TIMER, 24'h00012c);
    wr(`STRC_ADDR_SCAN, 24'h000001);
    gap(4'h0, 4'h0, 2'h0, 44, 300);
    wr(`STRC_ADDR_TIMER, 24'h000064);
    gap(4'h0, 4'h0, 2'h2, 100, 100);
    wr(`STRC_ADDR_TIMER, 24'h00012c);
    wdone(4'h0);
    repeat (4) @(negedge clk_sys_i);
    wx(`STRC_ADDR_SCAN, 24'h000001, 1'b0);
    wx(`STRC_ADDR_TIMER, 24'h00012c, 1'b1);
    // Single-channel restart groups
    wr(`STRC_ADDR_SCAN, 24'h000000);
    wr(`STRC_ADDR_CFG0, 24'h000003);
    wstart;
    wx(`STRC_ADDR_CFG3, 24'h0000c0, 1'b0);
    wx(`STRC_ADDR_OFFCAL, 24'h000123, 1'b0);
    wx(`STRC_ADDR_CFG3, 24'h0000c2, 1'b1);
    wstart;
    wx(`STRC_ADDR_OFFCAL, 24'h000123, 1'b1);
    wstart;
    wx(`STRC_ADDR_CFG3, 24'h0000c2, 1'b0);
    wx(`STRC_ADDR_SCAN, 24'h200000, 1'b0);
    wx(`STRC_ADDR_TIMER, 24'h000010, 1'b0);
    wx(`STRC_ADDR_MUX, 24'h000001, 1'b1);
    rlen(`STRC_ADDR_RSVB, 24'h000000, 1'b1);
    rlen(`STRC_ADDR_CFG0, 24'h000007, 1'b1);
    rlen(`STRC_ADDR_CFG0, 24'h000007, 1'b0);
    wr(`STRC_ADDR_CFG0, 24'h000006);
    wr(`STRC_ADDR_RSVC, 24'h000000);
    rlen(`STRC_ADDR_CFG0, 24'h000007, 1'b1);
    report_and_stop;
  end
endmodule
